// >>> verilog/ecw_core.sv
// Encoder latch, edge capture, position compare and watchdog logic.
// Assumes position count, direction, index, strobe and quadrature clock
// arrive synchronous to i_clock from the counting logic and the pins.
// Notes on behaviour
// RQ1 - Strobe latching enabled copies position count on each qualifying strobe
// RQ2 - Strobe edge: always rising, or rising forward and falling reverse
// RQ3 - Index latch trigger: index rising, index falling, or software marker
// RQ4 - Capture timer ticks at system clock over power of two 1 to 128
// RQ5 - Unit position event is quadrature clock over power of two to 2048
// RQ6 - Capture times interval between unit events, keeps last in period
// RQ7 - Capture logic runs only while the capture enable is on
// RQ8 - Capture timer overflow before next unit event sets overflow flag
// RQ9 - Direction change between two unit events sets direction flag
// RQ10 - Read latch mode: position read latches capture timer and period
// RQ11 - Timeout latch mode: unit timeout latches position, timer and period
// RQ12 - Unit period is a full 32-bit value, timeout when timer reaches it
// RQ13 - Compare sync output raised when position equals active compare
// RQ14 - Sync output goes to index pin or strobe pin as configured
// RQ15 - Shadowed compare loads on count zero or on match, as selected
// RQ16 - Without shadowing a compare write lands in the active register
// RQ17 - Sync pulse lasts four system clocks times programmed 1 to 4096
// RQ18 - Sync output polarity is active high or active low
// RQ19 - Watchdog restarts from zero on every quadrature clock edge
// RQ20 - Watchdog times out at 16-bit period without a quadrature edge
// RQ21 - Position error flag is meaningful only in reset-on-index mode
// RQ22 - Reset-on-index: index latches count, error unless zero or maximum
// RQ23 - Unit timeout occurs when unit timer matches unit period
// RQ24 - Error and watchdog flags stay set until software clears them
// RQ25 - Match during an active sync pulse restarts the width count
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps

module ecw_core #(
  parameter int CAP_W = 16
) (
  // Clock, reset, enable
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  // Encoder side
  input wire logic [31:0] i_position_count,
  input wire logic [31:0] i_max_position,
  input wire logic i_dir_forward,
  input wire logic i_quad_clock,
  input wire logic i_index,
  input wire logic i_strobe,
  // Register port
  input wire logic [4:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Sync output pins, enable low while driving
  output logic o_index_sync,
  output logic o_index_oe_n,
  output logic o_strobe_sync,
  output logic o_strobe_oe_n,
  // Events and flags
  output logic o_unit_timeout,
  output logic o_wdog_timeout,
  output logic o_pos_error,
  output logic o_capture_overflow_flag,
  output logic o_capture_dir_change_flag
);

  typedef struct packed {
    logic [15:0] ctrl;
    logic [2:0] cap_psc;
    logic [3:0] upe_psc;
    logic [31:0] unit_period;
    logic [31:0] cmp_active;
    logic [31:0] cmp_shadow;
    logic cmp_pending;
    logic [12:0] sync_width;
    logic [15:0] wdog_period;
    logic quad_prev;
    logic index_prev;
    logic strobe_prev;
    logic dir_prev;
    logic match_prev;
    logic [10:0] cap_div;
    logic [10:0] upe_div;
    logic [CAP_W-1:0] ctmr;
    logic [CAP_W-1:0] cprd;
    logic [CAP_W-1:0] ctmr_lat;
    logic [CAP_W-1:0] cprd_lat;
    logic [31:0] unit_timer;
    logic [31:0] strobe_lat;
    logic [31:0] index_lat;
    logic [31:0] pos_lat;
    logic [14:0] sync_cnt;
    logic [15:0] wdog_cnt;
    logic [4:0] flags;
    logic [31:0] rdata;
    logic index_sync;
    logic index_oe_n;
    logic strobe_sync;
    logic strobe_oe_n;
    logic unit_to;
  } ecw_state_t;

  localparam logic [CAP_W-1:0] CTMR_MAX = '1;

  ecw_state_t s_q;
  ecw_state_t s_d;

  // Low bits set for a power-of-two divide by 2**n
  function automatic logic [10:0] div_mask(input logic [3:0] n);
    logic [11:0] one_hot;
    one_hot = 12'h001 << n;
    return 11'(one_hot - 12'h001);
  endfunction

  logic w_ctrl;
  logic w_cmp;
  logic w_sts;
  logic qedge;
  logic upe;
  logic cap_tick;
  logic idx_rise;
  logic idx_fall;
  logic idx_evt;
  logic stb_rise;
  logic stb_fall;
  logic stb_evt;
  logic match_now;
  logic unit_to;
  logic sync_active;
  logic [1:0] idx_sel;
  logic [1:0] shd_mode;
  logic [12:0] width_eff;
  logic [4:0] flag_set;
  logic [4:0] flag_clr;

  always_comb begin
    s_d = s_q;
    w_ctrl = i_wr && (i_addr == ecw_pkg::OFS_CTRL);
    w_cmp = i_wr && (i_addr == ecw_pkg::OFS_COMPARE);
    w_sts = i_wr && (i_addr == ecw_pkg::OFS_STATUS);
    idx_sel = s_q.ctrl[ecw_pkg::CTL_IDX_SEL_LSB +: 2];
    shd_mode = s_q.ctrl[ecw_pkg::CTL_SHADOW_LSB +: 2];
    flag_set = 5'h00;
    flag_clr = w_sts ? i_wdata[4:0] : 5'h00;

    // Edge detection on encoder inputs
    qedge = i_quad_clock != s_q.quad_prev;
    idx_rise = i_index && !s_q.index_prev;
    idx_fall = !i_index && s_q.index_prev;
    stb_rise = i_strobe && !s_q.strobe_prev;
    stb_fall = !i_strobe && s_q.strobe_prev;
    s_d.quad_prev = i_quad_clock;
    s_d.index_prev = i_index;
    s_d.strobe_prev = i_strobe;

    // Unit position event from prescaled quadrature clock
    upe = qedge && ((s_q.upe_div & div_mask(s_q.upe_psc)) ==
                    div_mask(s_q.upe_psc)); // RQ5
    if (qedge) begin
      s_d.upe_div = 11'(s_q.upe_div + 11'h001);
    end
    // Capture timer tick from prescaled system clock
    cap_tick = (s_q.cap_div & div_mask({1'b0, s_q.cap_psc})) ==
               div_mask({1'b0, s_q.cap_psc}); // RQ4
    s_d.cap_div = 11'(s_q.cap_div + 11'h001);

    // Edge capture unit
    if (s_q.ctrl[ecw_pkg::CTL_CAPTURE_EN]) begin // RQ7
      if (upe) begin
        s_d.cprd = s_q.ctmr; // RQ6
        s_d.ctmr = '0;
        s_d.dir_prev = i_dir_forward;
        if (i_dir_forward != s_q.dir_prev) begin
          flag_set[ecw_pkg::STS_DIR_CHG] = 1'b1; // RQ9
        end
      end else if (cap_tick) begin
        if (s_q.ctmr == CTMR_MAX) begin
          flag_set[ecw_pkg::STS_CAP_OVF] = 1'b1; // RQ8
        end
        s_d.ctmr = CAP_W'(s_q.ctmr + 1'b1);
      end
    end

    // Unit timer
    unit_to = 1'b0;
    if (s_q.ctrl[ecw_pkg::CTL_UNIT_EN]) begin
      if (s_q.unit_timer == s_q.unit_period) begin // RQ12
        unit_to = 1'b1; // RQ23
        s_d.unit_timer = 32'h00000000;
        flag_set[ecw_pkg::STS_UNIT_TO] = 1'b1;
      end else begin
        s_d.unit_timer = 32'(s_q.unit_timer + 32'h00000001);
      end
    end
    s_d.unit_to = unit_to;

    // Latch on position read or on unit timeout
    if (s_q.ctrl[ecw_pkg::CTL_LATCH_ON_TO]) begin
      if (unit_to) begin
        s_d.pos_lat = i_position_count; // RQ11
        s_d.ctmr_lat = s_q.ctmr;
        s_d.cprd_lat = s_q.cprd;
      end
    end else if (i_rd && (i_addr == ecw_pkg::OFS_POSITION)) begin
      s_d.ctmr_lat = s_q.ctmr; // RQ10
      s_d.cprd_lat = s_q.cprd;
    end

    // Index event and latch
    case (idx_sel)
      ecw_pkg::IDX_RISE: idx_evt = idx_rise;
      ecw_pkg::IDX_FALL: idx_evt = idx_fall;
      ecw_pkg::IDX_SOFT: idx_evt = w_ctrl && i_wdata[ecw_pkg::CTL_SW_INDEX];
      default: idx_evt = idx_rise;
    endcase // RQ3
    if (idx_evt) begin
      if (s_q.ctrl[ecw_pkg::CTL_RST_ON_INDEX]) begin
        s_d.index_lat = i_position_count; // RQ22
        if (i_position_count != 32'h00000000 &&
            i_position_count != i_max_position) begin
          flag_set[ecw_pkg::STS_POS_ERR] = 1'b1; // RQ21
        end
      end else if (s_q.ctrl[ecw_pkg::CTL_IDX_LATCH_EN]) begin
        s_d.index_lat = i_position_count;
      end
    end

    // Strobe event and latch
    if (s_q.ctrl[ecw_pkg::CTL_STB_DIR_MODE]) begin
      stb_evt = i_dir_forward ? stb_rise : stb_fall; // RQ2
    end else begin
      stb_evt = stb_rise;
    end
    if (stb_evt && s_q.ctrl[ecw_pkg::CTL_STB_LATCH_EN]) begin
      s_d.strobe_lat = i_position_count; // RQ1
    end

    // Position compare with optional shadow load
    match_now = s_q.ctrl[ecw_pkg::CTL_CMP_EN] &&
                (i_position_count == s_q.cmp_active); // RQ13
    s_d.match_prev = match_now;
    if (s_q.cmp_pending &&
        ((shd_mode == ecw_pkg::SHD_ON_ZERO &&
          i_position_count == 32'h00000000) ||
         (shd_mode == ecw_pkg::SHD_ON_MATCH &&
          i_position_count == s_q.cmp_active))) begin
      s_d.cmp_active = s_q.cmp_shadow; // RQ15
      s_d.cmp_pending = 1'b0;
    end
    if (w_cmp) begin
      if (shd_mode == ecw_pkg::SHD_OFF) begin
        s_d.cmp_active = i_wdata; // RQ16
      end else begin
        s_d.cmp_shadow = i_wdata;
        s_d.cmp_pending = 1'b1;
      end
    end

    // Sync pulse stretcher, a new match reloads the width
    width_eff = (s_q.sync_width == 13'h0000) ? 13'h0001 : s_q.sync_width;
    if (match_now && !s_q.match_prev) begin
      s_d.sync_cnt = 15'(width_eff * ecw_pkg::SYNC_CYCLES_PER_UNIT); // RQ17 RQ25
    end else if (s_q.sync_cnt != 15'h0000) begin
      s_d.sync_cnt = 15'(s_q.sync_cnt - 15'h0001);
    end
    sync_active = s_d.sync_cnt != 15'h0000;
    s_d.index_oe_n = !(s_q.ctrl[ecw_pkg::CTL_CMP_EN] &&
                       !s_q.ctrl[ecw_pkg::CTL_SYNC_ON_STB]); // RQ14
    s_d.strobe_oe_n = !(s_q.ctrl[ecw_pkg::CTL_CMP_EN] &&
                        s_q.ctrl[ecw_pkg::CTL_SYNC_ON_STB]);
    s_d.index_sync = !s_d.index_oe_n &&
                     (sync_active ^ s_q.ctrl[ecw_pkg::CTL_SYNC_ACT_LOW]); // RQ18
    s_d.strobe_sync = !s_d.strobe_oe_n &&
                      (sync_active ^ s_q.ctrl[ecw_pkg::CTL_SYNC_ACT_LOW]);

    // Watchdog on the quadrature clock
    if (qedge) begin
      s_d.wdog_cnt = 16'h0000; // RQ19
    end else if (s_q.ctrl[ecw_pkg::CTL_WDOG_EN]) begin
      if (s_q.wdog_cnt == s_q.wdog_period) begin
        flag_set[ecw_pkg::STS_WDOG_TO] = 1'b1; // RQ20
        s_d.wdog_cnt = 16'h0000;
      end else begin
        s_d.wdog_cnt = 16'(s_q.wdog_cnt + 16'h0001);
      end
    end

    // Sticky flags, a new event beats a clear in the same cycle
    s_d.flags = (s_q.flags & ~flag_clr) | flag_set; // RQ24

    // Register writes
    if (w_ctrl) begin
      s_d.ctrl = {1'b0, i_wdata[14:0]};
    end
    if (i_wr && i_addr == ecw_pkg::OFS_PRESCALE) begin
      s_d.cap_psc = i_wdata[ecw_pkg::PSC_CAP_LSB +: 3];
      s_d.upe_psc = (i_wdata[ecw_pkg::PSC_UPE_LSB +: 4] > 4'hB) ? 4'hB :
                    i_wdata[ecw_pkg::PSC_UPE_LSB +: 4];
    end
    if (i_wr && i_addr == ecw_pkg::OFS_UNIT_PERIOD) begin
      s_d.unit_period = i_wdata;
    end
    if (i_wr && i_addr == ecw_pkg::OFS_SYNC_WIDTH) begin
      s_d.sync_width = (i_wdata[12:0] > 13'h1000) ? 13'h1000 : i_wdata[12:0];
    end
    if (i_wr && i_addr == ecw_pkg::OFS_WDOG_PERIOD) begin
      s_d.wdog_period = i_wdata[15:0];
    end

    // Register reads, data stands one cycle only
    s_d.rdata = 32'h00000000;
    if (i_rd) begin
      case (i_addr)
        ecw_pkg::OFS_CTRL: s_d.rdata = {16'h0000, s_q.ctrl};
        ecw_pkg::OFS_PRESCALE: s_d.rdata = {24'h000000, s_q.upe_psc,
                                            1'b0, s_q.cap_psc};
        ecw_pkg::OFS_POSITION: s_d.rdata = i_position_count;
        ecw_pkg::OFS_STROBE_LAT: s_d.rdata = s_q.strobe_lat;
        ecw_pkg::OFS_INDEX_LAT: s_d.rdata = s_q.index_lat;
        ecw_pkg::OFS_POS_LAT: s_d.rdata = s_q.pos_lat;
        ecw_pkg::OFS_CAP_TIMER: s_d.rdata = 32'(s_q.ctmr);
        ecw_pkg::OFS_CAP_PERIOD: s_d.rdata = 32'(s_q.cprd);
        ecw_pkg::OFS_CTMR_LAT: s_d.rdata = 32'(s_q.ctmr_lat);
        ecw_pkg::OFS_CPRD_LAT: s_d.rdata = 32'(s_q.cprd_lat);
        ecw_pkg::OFS_UNIT_PERIOD: s_d.rdata = s_q.unit_period;
        ecw_pkg::OFS_COMPARE: s_d.rdata = s_q.cmp_active;
        ecw_pkg::OFS_SYNC_WIDTH: s_d.rdata = {19'h00000, s_q.sync_width};
        ecw_pkg::OFS_WDOG_PERIOD: s_d.rdata = {16'h0000, s_q.wdog_period};
        ecw_pkg::OFS_STATUS: s_d.rdata = {27'h0000000, s_q.flags};
        default: s_d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      s_q <= '0;
      s_q.ctrl <= ecw_pkg::CTRL_RST;
      s_q.cap_psc <= ecw_pkg::CAP_PSC_RST;
      s_q.upe_psc <= ecw_pkg::UPE_PSC_RST;
      s_q.unit_period <= ecw_pkg::UNIT_PERIOD_RST;
      s_q.cmp_active <= ecw_pkg::COMPARE_RST;
      s_q.cmp_shadow <= ecw_pkg::COMPARE_RST;
      s_q.sync_width <= ecw_pkg::SYNC_WIDTH_RST;
      s_q.wdog_period <= ecw_pkg::WDOG_PERIOD_RST;
      s_q.index_oe_n <= 1'b1;
      s_q.strobe_oe_n <= 1'b1;
    end else if (i_clk_en) begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.rdata;
  assign o_index_sync = s_q.index_sync;
  assign o_index_oe_n = s_q.index_oe_n;
  assign o_strobe_sync = s_q.strobe_sync;
  assign o_strobe_oe_n = s_q.strobe_oe_n;
  assign o_unit_timeout = s_q.unit_to;
  assign o_wdog_timeout = s_q.flags[ecw_pkg::STS_WDOG_TO];
  assign o_pos_error = s_q.flags[ecw_pkg::STS_POS_ERR];
  assign o_capture_overflow_flag = s_q.flags[ecw_pkg::STS_CAP_OVF];
  assign o_capture_dir_change_flag = s_q.flags[ecw_pkg::STS_DIR_CHG];

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  AST_STROBE_LATCH: assert property ( // RQ1
    i_clk_en && stb_rise && !s_q.ctrl[ecw_pkg::CTL_STB_DIR_MODE] &&
    s_q.ctrl[ecw_pkg::CTL_STB_LATCH_EN] |=>
    s_q.strobe_lat == $past(i_position_count))
    else $error("strobe latch missed the position count");

  AST_CAPTURE_HOLD: assert property ( // RQ7
    i_clk_en && !s_q.ctrl[ecw_pkg::CTL_CAPTURE_EN] |=>
    $stable(s_q.ctmr) && $stable(s_q.cprd))
    else $error("capture unit moved while disabled");

  AST_TIMEOUT_LATCH: assert property ( // RQ11
    i_clk_en && unit_to && s_q.ctrl[ecw_pkg::CTL_LATCH_ON_TO] |=>
    s_q.pos_lat == $past(i_position_count) &&
    s_q.ctmr_lat == $past(s_q.ctmr) && o_unit_timeout)
    else $error("unit timeout did not latch together");

  AST_UNIT_TIMEOUT: assert property ( // RQ23
    i_clk_en && s_q.ctrl[ecw_pkg::CTL_UNIT_EN] &&
    s_q.unit_timer == s_q.unit_period |=>
    s_q.unit_timer == 32'h00000000 && s_q.flags[ecw_pkg::STS_UNIT_TO])
    else $error("unit timer missed its period");

  AST_DIRECT_COMPARE: assert property ( // RQ16
    i_clk_en && w_cmp && shd_mode == ecw_pkg::SHD_OFF |=>
    s_q.cmp_active == $past(i_wdata))
    else $error("unshadowed compare write not taken");

  AST_SYNC_WIDTH: assert property ( // RQ17
    i_clk_en && match_now && !s_q.match_prev |=>
    s_q.sync_cnt == 15'($past(width_eff) * 4) ##1 sync_active)
    else $error("sync width count wrong after match");

  AST_WDOG_RESTART: assert property ( // RQ19
    i_clk_en && qedge |=> s_q.wdog_cnt == 16'h0000)
    else $error("watchdog not restarted by quadrature edge");

  AST_WDOG_TIMEOUT: assert property ( // RQ20
    i_clk_en && !qedge && s_q.ctrl[ecw_pkg::CTL_WDOG_EN] &&
    s_q.wdog_cnt == s_q.wdog_period |=> o_wdog_timeout)
    else $error("watchdog did not time out at its period");

  AST_FLAG_STICKY: assert property ( // RQ24
    o_capture_overflow_flag && !(w_sts && i_wdata[ecw_pkg::STS_CAP_OVF]) |=>
    o_capture_overflow_flag)
    else $error("overflow flag dropped without a clear");

endmodule

// >>> verilog/ecw_pkg.sv
// Constants for the encoder capture, compare and watchdog block.
// Assumes a 100 MHz system clock and a plain word-addressed register port.
package ecw_pkg;

  // Register word offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_PRESCALE = 5'h01;
  localparam logic [4:0] OFS_POSITION = 5'h02;
  localparam logic [4:0] OFS_STROBE_LAT = 5'h03;
  localparam logic [4:0] OFS_INDEX_LAT = 5'h04;
  localparam logic [4:0] OFS_POS_LAT = 5'h05;
  localparam logic [4:0] OFS_CAP_TIMER = 5'h06;
  localparam logic [4:0] OFS_CAP_PERIOD = 5'h07;
  localparam logic [4:0] OFS_CTMR_LAT = 5'h08;
  localparam logic [4:0] OFS_CPRD_LAT = 5'h09;
  localparam logic [4:0] OFS_UNIT_PERIOD = 5'h0A;
  localparam logic [4:0] OFS_COMPARE = 5'h0B;
  localparam logic [4:0] OFS_SYNC_WIDTH = 5'h0C;
  localparam logic [4:0] OFS_WDOG_PERIOD = 5'h0D;
  localparam logic [4:0] OFS_STATUS = 5'h0E;

  // Control register fields
  localparam int CTL_STB_LATCH_EN = 0;
  localparam int CTL_STB_DIR_MODE = 1;
  localparam int CTL_IDX_SEL_LSB = 2;
  localparam int CTL_IDX_LATCH_EN = 4;
  localparam int CTL_CAPTURE_EN = 5;
  localparam int CTL_LATCH_ON_TO = 6;
  localparam int CTL_UNIT_EN = 7;
  localparam int CTL_CMP_EN = 8;
  localparam int CTL_SYNC_ON_STB = 9;
  localparam int CTL_SHADOW_LSB = 10;
  localparam int CTL_SYNC_ACT_LOW = 12;
  localparam int CTL_WDOG_EN = 13;
  localparam int CTL_RST_ON_INDEX = 14;
  localparam int CTL_SW_INDEX = 15;

  // Prescale register fields
  localparam int PSC_CAP_LSB = 0;
  localparam int PSC_UPE_LSB = 4;

  // Status register fields, write one to clear
  localparam int STS_CAP_OVF = 0;
  localparam int STS_DIR_CHG = 1;
  localparam int STS_POS_ERR = 2;
  localparam int STS_WDOG_TO = 3;
  localparam int STS_UNIT_TO = 4;

  // Index trigger and shadow load selections
  localparam logic [1:0] IDX_RISE = 2'h0;
  localparam logic [1:0] IDX_FALL = 2'h1;
  localparam logic [1:0] IDX_SOFT = 2'h2;
  localparam logic [1:0] SHD_OFF = 2'h0;
  localparam logic [1:0] SHD_ON_ZERO = 2'h1;
  localparam logic [1:0] SHD_ON_MATCH = 2'h2;

  // Reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [2:0] CAP_PSC_RST = 3'h7;
  localparam logic [3:0] UPE_PSC_RST = 4'h7;
  localparam logic [31:0] UNIT_PERIOD_RST = 32'h05F5E100;
  localparam logic [31:0] COMPARE_RST = 32'hFFFFFFFF;
  localparam logic [12:0] SYNC_WIDTH_RST = 13'h0001;
  localparam logic [15:0] WDOG_PERIOD_RST = 16'hFFFF;

  // Sync pulse is this many system clocks per programmed unit
  localparam int SYNC_CYCLES_PER_UNIT = 4;

endpackage

// >>> verif/ecw_enc_model.sv
// Encoder partner: position count, direction, quadrature clock, index
// and strobe. Assumes the testbench calls its tasks at clock edges.
`timescale 1ns/1ps
module ecw_enc_model (
  // Clock and limit
  input wire logic i_clock,
  input wire logic [31:0] i_max_position,
  // Encoder lines
  output logic [31:0] o_position_count,
  output logic o_dir_forward,
  output logic o_quad_clock,
  output logic o_index,
  output logic o_strobe
);
  initial begin
    o_position_count = 32'h0;
    o_dir_forward = 1'b1;
    o_quad_clock = 1'b0;
    o_index = 1'b0;
    o_strobe = 1'b0;
  end

  // Every quadrature edge moves the count one step, wrapping at the ends
  task automatic move(input int n, input logic fwd, input int gap);
    repeat (n) begin
      repeat (gap) @(posedge i_clock);
      o_dir_forward <= fwd;
      o_quad_clock <= ~o_quad_clock;
      if (fwd)
        o_position_count <= (o_position_count == i_max_position) ?
          32'h0 : o_position_count + 32'h1;
      else
        o_position_count <= (o_position_count == 32'h0) ?
          i_max_position : o_position_count - 32'h1;
    end
  endtask

  // Sets index, strobe and count together just after an edge
  task automatic lines(input logic idx, input logic stb,
                       input logic [31:0] pos, input logic fwd);
    @(posedge i_clock);
    o_index <= idx;
    o_strobe <= stb;
    o_position_count <= pos;
    o_dir_forward <= fwd;
  endtask
endmodule

// >>> verif/tb.sv
// Self-checking bench for the capture, compare and watchdog block.
// Assumes the encoder partner model and a 100 MHz clock.
`timescale 1ns/1ps
module tb;
  logic i_clock, i_resetn, i_clk_en, i_wr, i_rd;
  logic [31:0] i_max_position, i_wdata, o_rdata, pos, rd_v;
  logic [4:0] i_addr;
  logic dir, quad_clock, idx, stb, isync, ioe_n, ssync, soe_n;
  logic unit_to, wdog_to, pos_err, cov, cdc;
  int err_count = 0;
  int total_checks = 0;
  int n;
  logic [4:0] ra [8] = '{ecw_pkg::OFS_CTRL, ecw_pkg::OFS_PRESCALE,
    ecw_pkg::OFS_UNIT_PERIOD, ecw_pkg::OFS_COMPARE, ecw_pkg::OFS_SYNC_WIDTH,
    ecw_pkg::OFS_WDOG_PERIOD, ecw_pkg::OFS_STATUS, 5'h1F};
  logic [31:0] rv [8] = '{32'h0, 32'h77, 32'h05F5E100, 32'hFFFFFFFF,
    32'h1, 32'hFFFF, 32'h0, 32'h0};

  ecw_core #(.CAP_W(8)) ecw_core_i (.i_clock(i_clock), .i_resetn(i_resetn),
    .i_clk_en(i_clk_en), .i_position_count(pos),
    .i_max_position(i_max_position), .i_dir_forward(dir),
    .i_quad_clock(quad_clock), .i_index(idx), .i_strobe(stb), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_index_sync(isync), .o_index_oe_n(ioe_n), .o_strobe_sync(ssync),
    .o_strobe_oe_n(soe_n), .o_unit_timeout(unit_to),
    .o_wdog_timeout(wdog_to), .o_pos_error(pos_err),
    .o_capture_overflow_flag(cov), .o_capture_dir_change_flag(cdc));

  ecw_enc_model ecw_enc_model_i (.i_clock(i_clock),
    .i_max_position(i_max_position), .o_position_count(pos),
    .o_dir_forward(dir), .o_quad_clock(quad_clock), .o_index(idx),
    .o_strobe(stb));

  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge i_clock);
    #1;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [4:0] a);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    rd_v = o_rdata;
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_v, exp);
  endtask

  // Counts cycles in a window where the chosen sync pin sits at lvl
  task automatic pulse_len(input logic on_stb, input logic lvl);
    n = 0;
    repeat (60) begin
      cyc(1);
      if ((on_stb ? ssync : isync) === lvl)
        n++;
    end
  endtask

  task automatic wait_unit;
    n = 0;
    while (unit_to !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    if (n >= 200) begin
      err_count++;
      give_verdict;
    end
  endtask

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  initial begin
    repeat (100000) @(posedge i_clock);
    err_count++;
    give_verdict;
  end

  initial begin
    i_resetn = 1'b0;
    i_clk_en = 1'b1;
    i_max_position = 32'h3E7;
    i_addr = 5'h00;
    i_wdata = 32'h0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    repeat (10) @(posedge i_clock);
    i_resetn <= 1'b1;
    for (int k = 0; k < 8; k++)
      rchk(ra[k], rv[k]);
    ecw_enc_model_i.move(2, 1'b1, 4);
    cyc(4);
    rchk(ecw_pkg::OFS_CAP_PERIOD, 32'h0);
    // Strobe latching, plain and direction dependent
    wr(ecw_pkg::OFS_CTRL, 32'h1);
    ecw_enc_model_i.lines(1'b0, 1'b1, 32'h40, 1'b1);
    cyc(3);
    rchk(ecw_pkg::OFS_STROBE_LAT, 32'h40);
    wr(ecw_pkg::OFS_CTRL, 32'h3);
    ecw_enc_model_i.lines(1'b0, 1'b0, 32'h41, 1'b0);
    ecw_enc_model_i.lines(1'b0, 1'b1, 32'h42, 1'b0);
    cyc(3);
    rchk(ecw_pkg::OFS_STROBE_LAT, 32'h41);
    ecw_enc_model_i.lines(1'b0, 1'b0, 32'h43, 1'b0);
    cyc(3);
    rchk(ecw_pkg::OFS_STROBE_LAT, 32'h43);
    // Index latching on rise, fall and software marker
    wr(ecw_pkg::OFS_CTRL, 32'h10);
    ecw_enc_model_i.lines(1'b1, 1'b0, 32'h11, 1'b1);
    cyc(3);
    rchk(ecw_pkg::OFS_INDEX_LAT, 32'h11);
    wr(ecw_pkg::OFS_CTRL, 32'h14);
    ecw_enc_model_i.lines(1'b0, 1'b0, 32'h22, 1'b1);
    cyc(3);
    rchk(ecw_pkg::OFS_INDEX_LAT, 32'h22);
    wr(ecw_pkg::OFS_CTRL, 32'h18);
    ecw_enc_model_i.lines(1'b0, 1'b0, 32'h33, 1'b1);
    wr(ecw_pkg::OFS_CTRL, 32'h8018);
    cyc(3);
    rchk(ecw_pkg::OFS_INDEX_LAT, 32'h33);
    // Reset-on-index position check
    wr(ecw_pkg::OFS_CTRL, 32'h4000);
    ecw_enc_model_i.lines(1'b1, 1'b0, 32'h5, 1'b1);
    cyc(3);
    chk(pos_err, 1'b1);
    ecw_enc_model_i.lines(1'b0, 1'b0, 32'h0, 1'b1);
    cyc(20);
    chk(pos_err, 1'b1);
    wr(ecw_pkg::OFS_STATUS, 32'h4);
    ecw_enc_model_i.lines(1'b1, 1'b0, 32'h0, 1'b1);
    ecw_enc_model_i.lines(1'b0, 1'b0, 32'h0, 1'b1);
    ecw_enc_model_i.lines(1'b1, 1'b0, 32'h3E7, 1'b1);
    cyc(3);
    chk(pos_err, 1'b0);
    ecw_enc_model_i.lines(1'b0, 1'b0, 32'h4F, 1'b1);
    // Compare sync on the index pin, active high
    wr(ecw_pkg::OFS_CTRL, 32'h0);
    wr(ecw_pkg::OFS_COMPARE, 32'h50);
    wr(ecw_pkg::OFS_SYNC_WIDTH, 32'h2);
    wr(ecw_pkg::OFS_CTRL, 32'h100);
    cyc(3);
    rchk(ecw_pkg::OFS_COMPARE, 32'h50);
    chk(ioe_n, 1'b0);
    ecw_enc_model_i.move(1, 1'b1, 1);
    pulse_len(1'b0, 1'b1);
    chk(32'(n), 32'h8);
    // Strobe pin, active low, width zero acts as one
    wr(ecw_pkg::OFS_SYNC_WIDTH, 32'h0);
    wr(ecw_pkg::OFS_CTRL, 32'h1300);
    ecw_enc_model_i.lines(1'b0, 1'b0, 32'h4F, 1'b1);
    cyc(3);
    chk({ioe_n, soe_n}, 2'h2);
    ecw_enc_model_i.move(1, 1'b1, 1);
    pulse_len(1'b1, 1'b0);
    chk(32'(n), 32'h4);
    // Shadow loads at count zero, then at match
    wr(ecw_pkg::OFS_CTRL, 32'h500);
    wr(ecw_pkg::OFS_COMPARE, 32'h99);
    rchk(ecw_pkg::OFS_COMPARE, 32'h50);
    ecw_enc_model_i.lines(1'b0, 1'b0, 32'h0, 1'b1);
    cyc(3);
    rchk(ecw_pkg::OFS_COMPARE, 32'h99);
    wr(ecw_pkg::OFS_CTRL, 32'h900);
    wr(ecw_pkg::OFS_COMPARE, 32'h77);
    ecw_enc_model_i.lines(1'b0, 1'b0, 32'h98, 1'b1);
    cyc(3);
    rchk(ecw_pkg::OFS_COMPARE, 32'h99);
    ecw_enc_model_i.move(1, 1'b1, 1);
    cyc(3);
    rchk(ecw_pkg::OFS_COMPARE, 32'h77);
    // Unit timer period and time-out latching
    wr(ecw_pkg::OFS_UNIT_PERIOD, 32'h9);
    wr(ecw_pkg::OFS_CTRL, 32'hC0);
    wait_unit;
    cyc(1);
    wait_unit;
    chk(32'(n + 1), 32'hA);
    rchk(ecw_pkg::OFS_POS_LAT, pos);
    wr(ecw_pkg::OFS_CTRL, 32'h0);
    wr(ecw_pkg::OFS_STATUS, 32'h10);
    // Watchdog restarts on edges, times out when they stop
    wr(ecw_pkg::OFS_WDOG_PERIOD, 32'h14);
    wr(ecw_pkg::OFS_CTRL, 32'h2000);
    ecw_enc_model_i.move(4, 1'b1, 15);
    cyc(1);
    chk(wdog_to, 1'b0);
    cyc(25);
    chk(wdog_to, 1'b1);
    wr(ecw_pkg::OFS_CTRL, 32'h0);
    cyc(30);
    chk(wdog_to, 1'b1);
    wr(ecw_pkg::OFS_STATUS, 32'h8);
    cyc(2);
    chk(wdog_to, 1'b0);
    // Edge capture, prescaled unit events, flags
    wr(ecw_pkg::OFS_PRESCALE, 32'h0);
    wr(ecw_pkg::OFS_CTRL, 32'h20);
    ecw_enc_model_i.move(3, 1'b1, 6);
    cyc(2);
    rchk(ecw_pkg::OFS_CAP_PERIOD, 32'h5);
    wr(ecw_pkg::OFS_PRESCALE, 32'h10);
    ecw_enc_model_i.move(4, 1'b1, 6);
    cyc(2);
    rchk(ecw_pkg::OFS_CAP_PERIOD, 32'hB);
    rd(ecw_pkg::OFS_POSITION);
    rchk(ecw_pkg::OFS_CPRD_LAT, 32'hB);
    wr(ecw_pkg::OFS_STATUS, 32'h2);
    cyc(2);
    chk(cdc, 1'b0);
    ecw_enc_model_i.move(2, 1'b0, 6);
    cyc(2);
    chk(cdc, 1'b1);
    cyc(300);
    chk(cov, 1'b1);
    wr(ecw_pkg::OFS_CTRL, 32'h0);
    give_verdict;
  end
endmodule
